// [ebc_pkg.sv]
// shared types and constants for the external bus control block
package ebc_pkg;
  localparam int EBC_DW = 16;
  localparam int EBC_AW = 16;
  localparam int EBC_GPIO_W = 4;
  // access spaces
  typedef enum logic [1:0] {
    EBC_SP_PROG,
    EBC_SP_DATA,
    EBC_SP_IO
  } ebc_space_t;
  // core-side access request
  typedef struct packed {
    ebc_space_t space;
    logic write;
    logic global_access;
    logic [EBC_AW-1:0] addr;
    logic [EBC_DW-1:0] wdata;
  } ebc_req_t;
  // gathered memory-control pin levels
  typedef struct packed {
    logic prog_n;
    logic data_n;
    logic io_n;
    logic rw;
    logic rd_n;
    logic we_n;
    logic bus_cycle_strobe_n_n;
    logic br_n;
  } ebc_ctl_t;
  localparam ebc_ctl_t EBC_CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [EBC_GPIO_W-1:0] EBC_GPIO_DIR_RST = 4'h0;
  localparam logic [EBC_GPIO_W-1:0] EBC_GPIO_OUT_RST = 4'h0;
  localparam logic EBC_FLAG_RST = 1'b0;
  localparam logic [EBC_AW-1:0] EBC_ADDR_RST = 16'h0000;
  localparam logic [EBC_DW-1:0] EBC_DATA_RST = 16'h0000;
endpackage

// [ebc_space_dec.sv]
// one-hot space select decode for an active bus cycle
`timescale 1ns/10ps
`default_nettype none
module ebc_space_dec
  import ebc_pkg::*;
(
  input wire logic active,
  input wire ebc_space_t space,
  output logic prog_n,
  output logic data_n,
  output logic io_n
);
  wire is_prog = active && (space == EBC_SP_PROG);
  wire is_data = active && (space == EBC_SP_DATA);
  wire is_io = active && (space == EBC_SP_IO);
  assign prog_n = !is_prog; // R1
  assign data_n = !is_data; // R2
  assign io_n = !is_io; // R3
endmodule // ebc_space_dec
`default_nettype wire

// [ebc_gpio.sv]
// four general-purpose pins with direction and level latches
`timescale 1ns/10ps
`default_nettype none
module ebc_gpio
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cfg_we,
  input wire logic [EBC_GPIO_W-1:0] cfg_dir,
  input wire logic [EBC_GPIO_W-1:0] cfg_out,
  input wire logic float_en,
  input wire logic [EBC_GPIO_W-1:0] pin_i,
  output logic [EBC_GPIO_W-1:0] pin_o,
  output logic [EBC_GPIO_W-1:0] pin_oe,
  output logic [EBC_GPIO_W-1:0] pin_level
);
  logic [EBC_GPIO_W-1:0] dir;
  logic [EBC_GPIO_W-1:0] lvl;
  logic [EBC_GPIO_W-1:0] samp;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dir <= EBC_GPIO_DIR_RST; // R16
      lvl <= EBC_GPIO_OUT_RST;
    end else if (cfg_we) begin
      dir <= cfg_dir; // R16
      lvl <= cfg_out;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      samp <= EBC_GPIO_OUT_RST;
    end else begin
      samp <= pin_i;
    end
  end
  assign pin_o = lvl;
  assign pin_oe = float_en ? '0 : dir; // R13
  assign pin_level = samp;
endmodule // ebc_gpio
`default_nettype wire

// [ebc_bus_ctrl.sv]
// external memory and I/O bus sequencer with hold, flag and branch input
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: program select low only during an off-chip program access.
// R2: data select low only during an off-chip data access.
// R3: I/O select low only during an external I/O access.
// R4: ready low stretches the cycle; resampled every following cycle.
// R5: direction line high except during an external write.
// R6: read strobe low on every external read, usable as output enable.
// R7: data bus driven from the falling edge of write strobe.
// R8: write data held through the rising edge of write strobe.
// R9: write strobe low on every external write.
// R10: bus-cycle strobe low only during an active external cycle.
// R11: global bus request asserted with every global data access.
// R12: in hold, bus and controls float and hold acknowledge is asserted.
// R13: float input low puts every output pin in high impedance.
// R14: flag output latched under software control.
// R15: branch taken when the branch input is sampled low.
// R16: general pins are inputs at reset, then set by port control.
// R17: data bus floats whenever the direction line is high.
// R18: at most one space select asserted per bus cycle.
module ebc_bus_ctrl
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  // core request side
  input wire logic req_valid,
  input wire ebc_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [EBC_DW-1:0] rsp_rdata,
  // hold request from the interrupt logic
  input wire logic hold_req,
  // flag and branch poll
  input wire logic flag_we,
  input wire logic flag_val,
  input wire logic branch_on_input_instruction,
  output logic branch_taken,
  // port control writes for the general pins
  input wire logic async_port_control_reg_we,
  input wire logic [EBC_GPIO_W-1:0] async_port_control_reg_dir,
  input wire logic [EBC_GPIO_W-1:0] async_port_control_reg_out,
  output logic [EBC_GPIO_W-1:0] general_io_level,
  // external pins
  input wire logic float_n,
  input wire logic ready,
  input wire logic branch_condition_in_n,
  output logic [EBC_AW-1:0] addr_o,
  output logic addr_oe,
  input wire logic [EBC_DW-1:0] data_i,
  output logic [EBC_DW-1:0] data_o,
  output logic data_oe,
  output logic program_space_select_n,
  output logic data_space_select_n,
  output logic io_space_select_n,
  output logic rw,
  output logic rd_n,
  output logic we_n,
  output logic bus_cycle_strobe_n,
  output logic global_bus_request_n,
  output logic ctl_oe,
  output logic hold_acknowledge_n,
  output logic hold_acknowledge_oe,
  output logic external_flag_out,
  output logic external_flag_oe,
  output logic [EBC_GPIO_W-1:0] general_io_pins_o,
  output logic [EBC_GPIO_W-1:0] general_io_pins_oe,
  input wire logic [EBC_GPIO_W-1:0] general_io_pins_i
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_TAIL,
    ST_HOLD
  } ebc_state_t;

  ebc_state_t state;
  ebc_state_t next_state;
  ebc_req_t cur;
  logic [EBC_DW-1:0] rdata;
  logic done;
  logic flag;
  logic branch;
  logic hold_ack;

  wire float_en = !float_n;
  wire take = (state == ST_IDLE) && req_valid && !hold_req;
  wire in_cycle = (state == ST_ACCESS) || (state == ST_TAIL);
  wire cyc_write = in_cycle && cur.write;
  wire cyc_read = in_cycle && !cur.write;
  wire finish = (state == ST_ACCESS) && ready; // R4
  // write strobe low only in the access phase; data stays in the tail
  wire we_phase = (state == ST_ACCESS) && cur.write;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (hold_req) begin
          next_state = ST_HOLD; // R12
        end else if (req_valid) begin
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (ready) begin
          next_state = ST_TAIL; // R4
        end
      end
      ST_TAIL: begin
        next_state = ST_IDLE;
      end
      ST_HOLD: begin
        if (!hold_req) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cur <= '0;
    end else if (take) begin
      cur <= req;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdata <= EBC_DATA_RST;
      done <= 1'b0;
    end else begin
      done <= finish;
      if (finish && !cur.write) begin
        rdata <= data_i;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag <= EBC_FLAG_RST;
    end else if (flag_we) begin
      flag <= flag_val; // R14
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      branch <= 1'b0;
    end else begin
      branch <= branch_on_input_instruction && !branch_condition_in_n; // R15
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_ack <= 1'b0;
    end else begin
      hold_ack <= (next_state == ST_HOLD); // R12
    end
  end

  ebc_space_dec u_dec (
    .active(in_cycle),
    .space(cur.space),
    .prog_n(program_space_select_n),
    .data_n(data_space_select_n),
    .io_n(io_space_select_n)
  ); // R18

  ebc_gpio u_gpio (
    .mclk(mclk),
    .resetn(resetn),
    .cfg_we(async_port_control_reg_we),
    .cfg_dir(async_port_control_reg_dir),
    .cfg_out(async_port_control_reg_out),
    .float_en(float_en),
    .pin_i(general_io_pins_i),
    .pin_o(general_io_pins_o),
    .pin_oe(general_io_pins_oe),
    .pin_level(general_io_level)
  ); // R16

  assign req_ready = (state == ST_IDLE) && !hold_req;
  assign rsp_valid = done;
  assign rsp_rdata = rdata;
  assign branch_taken = branch;

  assign addr_o = in_cycle ? cur.addr : EBC_ADDR_RST;
  assign data_o = cur.wdata;
  assign rw = !cyc_write; // R5
  assign rd_n = !cyc_read; // R6
  assign we_n = !we_phase; // R9
  assign bus_cycle_strobe_n = !in_cycle; // R10
  assign global_bus_request_n = !(in_cycle && cur.global_access && (cur.space == EBC_SP_DATA)); // R11
  // driven from the write strobe fall through the tail, past its rise
  assign data_oe = cyc_write && !float_en && !hold_ack; // R7 R8 R17
  assign addr_oe = !float_en && !hold_ack; // R12 R13
  assign ctl_oe = !float_en && !hold_ack; // R12 R13
  assign hold_acknowledge_n = !hold_ack; // R12
  assign hold_acknowledge_oe = !float_en; // R13
  assign external_flag_out = flag;
  assign external_flag_oe = !float_en; // R13
endmodule // ebc_bus_ctrl
`default_nettype wire

// [ebc_bus_ctrl_sva.sv]
// assertion checker for the external bus control pins
`timescale 1ns/10ps
`default_nettype none
module ebc_bus_ctrl_chk
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ready,
  input wire logic float_n,
  input wire logic branch_on_input_instruction,
  input wire logic branch_condition_in_n,
  input wire logic branch_taken,
  input wire logic program_space_select_n,
  input wire logic data_space_select_n,
  input wire logic io_space_select_n,
  input wire logic rw,
  input wire logic rd_n,
  input wire logic we_n,
  input wire logic bus_cycle_strobe_n,
  input wire logic global_bus_request_n,
  input wire logic ctl_oe,
  input wire logic data_oe,
  input wire logic [EBC_DW-1:0] data_o,
  input wire logic hold_acknowledge_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire [2:0] sel = {program_space_select_n, data_space_select_n, io_space_select_n};
  AST_SEL: assert property ($onehot0(~sel) && (sel == 3'h7) == bus_cycle_strobe_n)
    else $error("space select out of cycle");
  AST_RW: assert property (!rw |-> rd_n && !bus_cycle_strobe_n) else $error("rw low");
  AST_RD: assert property (!rd_n |-> rw && !bus_cycle_strobe_n) else $error("rd low");
  AST_WE: assert property (!we_n |-> !rw && data_oe) else $error("we low");
  AST_WHOLD: assert property ($rose(we_n) |-> data_oe && $stable(data_o)) else $error("hold");
  AST_WAIT: assert property (!we_n && !ready |=> !we_n) else $error("wait");
  AST_DOE: assert property (data_oe |-> !rw) else $error("data driven");
  AST_GBR: assert property (!global_bus_request_n |-> !data_space_select_n) else $error("br");
  AST_HOLD: assert property (!hold_acknowledge_n |-> !ctl_oe && !data_oe) else $error("hold");
  AST_FLOAT: assert property (!float_n |-> !ctl_oe && !data_oe) else $error("float");
  AST_BR: assert property (branch_on_input_instruction |=> branch_taken == !$past(branch_condition_in_n))
    else $error("branch");
  cover property (!we_n ##1 we_n);
  cover property (!rd_n && !ready);
  cover property (!hold_acknowledge_n);
endmodule // ebc_bus_ctrl_chk
`default_nettype wire

// [ebc_ext_mem.sv]
// external memory model answering the bus with programmable wait cycles
`timescale 1ns/10ps
`default_nettype none
module ebc_ext_mem
  import ebc_pkg::*;
(
  input wire logic mclk,
  input wire logic bus_cycle_strobe_n_n,
  input wire logic rd_n,
  input wire logic we_n,
  input wire logic [3:0] addr,
  input wire logic [EBC_DW-1:0] wdata,
  input wire logic wdrive,
  input wire logic [1:0] waits,
  output logic ready,
  output logic [EBC_DW-1:0] rdata
);
  logic [EBC_DW-1:0] mem [16];
  logic [EBC_DW-1:0] last = 16'h0000;
  logic [1:0] cnt;
  assign ready = bus_cycle_strobe_n_n || cnt >= waits;
  // released bus shows the inverse of the last word
  assign rdata = rd_n ? ~last : mem[addr];
  always_ff @(posedge mclk) begin
    cnt <= bus_cycle_strobe_n_n ? 2'h0 : cnt + 2'(cnt < waits);
    if (!rd_n) last <= mem[addr];
  end
  always @(posedge we_n) mem[addr] <= wdrive ? wdata : ~wdata;
endmodule // ebc_ext_mem
`default_nettype wire

// [external_bus_control_bench.sv]
// self-checking bench for the external bus sequencer
`timescale 1ns/10ps
`default_nettype none
module external_bus_control_bench;
  import ebc_pkg::*;
  logic mclk = 0, resetn = 0, req_valid = 0, hold_req = 0, flag_we = 0, flag_val = 0;
  logic branch_on_input_instruction = 0, async_port_control_reg_we = 0, float_n = 1;
  logic branch_condition_in_n = 1, ready, req_ready, rsp_valid, branch_taken, addr_oe, data_oe;
  logic [3:0] async_port_control_reg_dir = 4'h0, async_port_control_reg_out = 4'h0;
  logic [3:0] general_io_pins_i = 4'h3, general_io_level, general_io_pins_o, general_io_pins_oe;
  logic [15:0] rsp_rdata, addr_o, data_i, data_o;
  logic program_space_select_n, data_space_select_n, io_space_select_n, rw, rd_n, we_n;
  logic bus_cycle_strobe_n, global_bus_request_n, ctl_oe, hold_acknowledge_n;
  logic hold_acknowledge_oe, external_flag_out, external_flag_oe;
  ebc_req_t req = '0;
  logic [1:0] waits = 2'h0;
  int fails = 0, check_count = 0;
  initial forever #5 mclk = ~mclk;
  ebc_bus_ctrl dut (.*);
  ebc_ext_mem mem (.mclk, .bus_cycle_strobe_n_n(bus_cycle_strobe_n), .rd_n, .we_n, .addr(addr_o[3:0]),
    .wdata(data_o), .wdrive(data_oe), .waits, .ready, .rdata(data_i));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic acc(ebc_space_t sp, logic wr, gl, logic [15:0] a, d, logic [1:0] w);
    logic [2:0] sel;
    logic brq;
    int n;
    sel = 3'h7;
    brq = 1;
    n = 0;
    @(posedge mclk);
    waits <= w;
    req <= '{sp, wr, gl, a, d};
    req_valid <= 1;
    @(posedge mclk);
    req_valid <= 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      sel &= {program_space_select_n, data_space_select_n, io_space_select_n};
      brq &= global_bus_request_n;
    end while (!rsp_valid && n < 20);
    chk("cycles", 16'(1 + w), 16'(n));
    chk("select", 16'(3'(~(3'h4 >> sp))), 16'(sel));
    chk("bus request", 16'(!(gl && sp == EBC_SP_DATA)), 16'(brq));
    if (!wr) chk("read data", d, rsp_rdata);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1;
    #1;
    chk("gpio oe", 16'h0000, 16'(general_io_pins_oe));
    chk("idle pins", 16'h00ff, {program_space_select_n, data_space_select_n, io_space_select_n,
      rw, rd_n, we_n, bus_cycle_strobe_n, global_bus_request_n});
    for (int s = 0; s < 3; s++) begin
      acc(ebc_space_t'(s), 1, s == 1, 16'h0005 + 16'(s), 16'ha5c3 ^ 16'(s), 2'h0);
      acc(ebc_space_t'(s), 0, s == 1, 16'h0005 + 16'(s), 16'ha5c3 ^ 16'(s), 2'(s));
    end
    @(posedge mclk);
    hold_req <= 1;
    repeat (2) @(posedge mclk);
    #1;
    chk("hold", 16'h0000, {hold_acknowledge_n, ctl_oe, addr_oe, data_oe, req_ready});
    @(posedge mclk);
    hold_req <= 0;
    async_port_control_reg_dir <= 4'h5;
    async_port_control_reg_out <= 4'ha;
    async_port_control_reg_we <= 1;
    flag_we <= 1;
    flag_val <= 1;
    @(posedge mclk);
    async_port_control_reg_we <= 0;
    flag_we <= 0;
    flag_val <= 0;
    @(posedge mclk);
    #1;
    chk("gpio oe", 16'h0005, 16'(general_io_pins_oe));
    chk("gpio out", 16'h0000, 16'((general_io_pins_o ^ 4'ha) & 4'h5));
    chk("gpio level", 16'h0003, 16'(general_io_level));
    chk("flag", 16'h0001, 16'(external_flag_out));
    @(posedge mclk);
    float_n <= 0;
    @(posedge mclk);
    #1;
    chk("float", 16'h0000, {ctl_oe, addr_oe, data_oe, hold_acknowledge_oe, external_flag_oe,
      general_io_pins_oe});
    @(posedge mclk);
    float_n <= 1;
    for (int b = 0; b < 2; b++) begin
      @(posedge mclk);
      branch_condition_in_n <= b[0];
      branch_on_input_instruction <= 1;
      @(posedge mclk);
      branch_on_input_instruction <= 0;
      #1;
      chk("branch", 16'(!b[0]), 16'(branch_taken));
    end
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule // external_bus_control_bench
bind ebc_bus_ctrl ebc_bus_ctrl_chk chk_i (.*);
`default_nettype wire
